// File: hw/bcq_pkg.sv
// Purpose: Constants for the breakpoint compare qualifier
// Assumes: 8-bit register port, 16-bit address and data bus, 6-bit page
// Notes:   Register index values are local choices
package bcq_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_QUAL_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CMPA_EXT  = 4'h1;
  localparam logic [3:0] ADDR_CMPA_HIGH = 4'h2;
  localparam logic [3:0] ADDR_CMPA_LOW  = 4'h3;
  localparam logic [3:0] ADDR_CMPB_EXT  = 4'h4;
  localparam logic [3:0] ADDR_CMPB_HIGH = 4'h5;
  localparam logic [3:0] ADDR_CMPB_LOW  = 4'h6;
  localparam logic [3:0] ADDR_MODE_CTRL = 4'h7;
  localparam logic [3:0] ADDR_STATUS    = 4'h8;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MASK_A_HIGH_BIT = 7;
  localparam int MASK_A_LOW_BIT  = 6;
  localparam int MASK_B_HIGH_BIT = 5;
  localparam int MASK_B_LOW_BIT  = 4;
  localparam int DIR_EN_A_BIT    = 3;
  localparam int DIR_VAL_A_BIT   = 2;
  localparam int DIR_EN_B_BIT    = 1;
  localparam int DIR_VAL_B_BIT   = 0;
  localparam int MODE_BKP_BIT    = 2;
  localparam int MODE_FULL_BIT   = 1;
  localparam int MODE_DBG_BIT    = 0;
  localparam int EXT_W           = 6;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] QUAL_CTRL_RST = 8'h00;
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam logic [2:0] MODE_RST      = 3'h0;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;

endpackage : bcq_pkg

// File: hw/bcq_top.sv
// Purpose: Breakpoint comparator A/B qualification with register port
// Assumes: Core bus signals are on the same clock as this block
// Notes:   Match outputs are registered one cycle after the bus cycle
//
// Summary of operation
// - Mask A in control bits 7:6, mask B in bits 5:4.
// - Mask A acts in dual and full modes on first address.
// - Mask A full, page selected: 20-bit paged compare of extended bits.
// - Mask A full, no page selected: 16-bit compare of address 15:0.
// - Mask A 1:0 behaves as full compare.
// - Mask 0:1 skips low byte, 1:1 skips both; page only if selected.
// - Mask 1:1 matches any access to the page, only when page selected.
// - Dual mode comparator B uses same address masking as A.
// - Mask B 1:0 in dual mode behaves as full compare.
// - Full mode mask B selects compared data bytes.
// - Full mode data compare ignores comparator B extended bits.
// - Direction enable A includes cycle direction in match A.
// - Direction value A: 0 write, 1 read; unused when disabled.
// - Direction enable B includes cycle direction in match B.
// - Direction value B: 0 write, 1 read; unused when disabled.
// - Full mode ignores both comparator B direction bits.
// - Full mode: A matches address, B data; dual: both addresses.
// - Trace debug mode forces mask A bits to zero.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps

module bcq_top (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [15:0] cpu_data,
  input  wire logic [5:0]  program_page_select,
  input  wire logic        page_access,
  input  wire logic        cpu_read,
  input  wire logic        cpu_valid,
  output logic             match_a,
  output logic             match_b
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] qual_ctrl;
    logic [7:0] cmpa_ext;
    logic [7:0] cmpa_high;
    logic [7:0] cmpa_low;
    logic [7:0] cmpb_ext;
    logic [7:0] cmpb_high;
    logic [7:0] cmpb_low;
    logic [2:0] mode;
    logic [7:0] rdata;
    logic       match_a;
    logic       match_b;
  } bcq_state_s;

  bcq_state_s st_q;
  bcq_state_s st_d;

  // ****************************************************************
  // Compare helpers
  // ****************************************************************

  // Address compare with byte masks and page qualification.
  // A 1:0 mask would keep the low byte and drop the high one, which
  // names no useful range, so it falls back to a full compare.
  // Paged compares skip address bits 15:14, so several windows alias.
  function automatic logic bcq_addr_hit(
    input logic [1:0] mask,
    input logic [7:0] ext,
    input logic [7:0] high,
    input logic [7:0] low,
    input logic [15:0] addr,
    input logic [5:0] page,
    input logic        paged
  );
    logic ext_ok;
    logic high_ok;
    logic low_ok;
    logic eff_low;
    logic eff_high;
    begin
      eff_low  = mask[0];
      eff_high = mask[1] & mask[0];  // 1:0 treated as full
      ext_ok   = !paged || (ext[bcq_pkg::EXT_W-1:0] == page);
      if (paged)
      begin
        high_ok = (high[5:0] == addr[13:8]);  // Paged 20-bit
      end
      else
      begin
        high_ok = (high == addr[15:8]);       // Plain 16-bit
      end
      low_ok = (low == addr[7:0]);
      if (eff_high)
      begin
        bcq_addr_hit = paged && ext_ok;       // Page-wide hit
      end
      else
      begin
        bcq_addr_hit = ext_ok && high_ok && (eff_low || low_ok);
      end
    end
  endfunction : bcq_addr_hit

  // Direction qualifier: value 1 matches read, 0 matches write
  // A cleared enable lets reads and writes through alike
  function automatic logic bcq_dir_ok(
    input logic en,
    input logic val,
    input logic rd
  );
    begin
      bcq_dir_ok = !en || (val == rd);
    end
  endfunction : bcq_dir_ok

  // Register index decode, shared by the write and read chains;
  // unmapped indices select nothing, so writes drop and reads give zero
  function automatic logic [8:0] bcq_reg_sel(
    input logic [3:0] idx
  );
    begin
      bcq_reg_sel = 9'h000;
      if (idx == bcq_pkg::ADDR_QUAL_CTRL)
      begin
        bcq_reg_sel[bcq_pkg::ADDR_QUAL_CTRL] = 1'b1;
      end
      else if (idx == bcq_pkg::ADDR_CMPA_EXT)
      begin
        bcq_reg_sel[bcq_pkg::ADDR_CMPA_EXT] = 1'b1;
      end
      else if (idx == bcq_pkg::ADDR_CMPA_HIGH)
      begin
        bcq_reg_sel[bcq_pkg::ADDR_CMPA_HIGH] = 1'b1;
      end
      else if (idx == bcq_pkg::ADDR_CMPA_LOW)
      begin
        bcq_reg_sel[bcq_pkg::ADDR_CMPA_LOW] = 1'b1;
      end
      else if (idx == bcq_pkg::ADDR_CMPB_EXT)
      begin
        bcq_reg_sel[bcq_pkg::ADDR_CMPB_EXT] = 1'b1;
      end
      else if (idx == bcq_pkg::ADDR_CMPB_HIGH)
      begin
        bcq_reg_sel[bcq_pkg::ADDR_CMPB_HIGH] = 1'b1;
      end
      else if (idx == bcq_pkg::ADDR_CMPB_LOW)
      begin
        bcq_reg_sel[bcq_pkg::ADDR_CMPB_LOW] = 1'b1;
      end
      else if (idx == bcq_pkg::ADDR_MODE_CTRL)
      begin
        bcq_reg_sel[bcq_pkg::ADDR_MODE_CTRL] = 1'b1;
      end
      else if (idx == bcq_pkg::ADDR_STATUS)
      begin
        bcq_reg_sel[bcq_pkg::ADDR_STATUS] = 1'b1;
      end
    end
  endfunction : bcq_reg_sel

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic [1:0] mask_a;
  logic [1:0] mask_b;
  logic       full_mode;
  logic       hit_a;
  logic       hit_b;
  logic       data_hi_ok;
  logic       data_lo_ok;
  logic [8:0] reg_sel;

  // Register writes, reads and comparator evaluation
  always_comb
  begin
    st_d      = st_q;
    full_mode = st_q.mode[bcq_pkg::MODE_FULL_BIT];
    mask_a    = {st_q.qual_ctrl[bcq_pkg::MASK_A_HIGH_BIT],
                 st_q.qual_ctrl[bcq_pkg::MASK_A_LOW_BIT]};
    mask_b    = {st_q.qual_ctrl[bcq_pkg::MASK_B_HIGH_BIT],
                 st_q.qual_ctrl[bcq_pkg::MASK_B_LOW_BIT]};
    if (st_q.mode[bcq_pkg::MODE_DBG_BIT] &&
        !st_q.mode[bcq_pkg::MODE_BKP_BIT])
    begin
      mask_a = 2'h0;
    end
    // Comparator A always matches addresses
    hit_a = bcq_addr_hit(mask_a, st_q.cmpa_ext, st_q.cmpa_high,
                         st_q.cmpa_low, cpu_addr, program_page_select,
                         page_access)
            && bcq_dir_ok(st_q.qual_ctrl[bcq_pkg::DIR_EN_A_BIT],
                          st_q.qual_ctrl[bcq_pkg::DIR_VAL_A_BIT],
                          cpu_read);
    // Data byte compares, extended bits unused
    // High mask bit drops the high data byte, low bit the low byte
    data_hi_ok = mask_b[1] || (st_q.cmpb_high == cpu_data[15:8]);
    data_lo_ok = mask_b[0] || (st_q.cmpb_low == cpu_data[7:0]);
    if (full_mode)
    begin
      hit_b = data_hi_ok && data_lo_ok;        // Direction ignored
    end
    else
    begin
      hit_b = bcq_addr_hit(mask_b, st_q.cmpb_ext, st_q.cmpb_high,
                           st_q.cmpb_low, cpu_addr, program_page_select,
                           page_access)
              && bcq_dir_ok(st_q.qual_ctrl[bcq_pkg::DIR_EN_B_BIT],
                            st_q.qual_ctrl[bcq_pkg::DIR_VAL_B_BIT],
                            cpu_read);
    end
    // In full mode A is address and B is data
    st_d.match_a = cpu_valid && hit_a;
    st_d.match_b = cpu_valid && hit_b;

    // One decode serves both the write and the read chain
    reg_sel = bcq_reg_sel(reg_addr);

    // Register writes
    if (reg_wr)
    begin
      if (reg_sel[bcq_pkg::ADDR_QUAL_CTRL])
      begin
        st_d.qual_ctrl = reg_wdata;
      end
      else if (reg_sel[bcq_pkg::ADDR_CMPA_EXT])
      begin
        st_d.cmpa_ext = reg_wdata;
      end
      else if (reg_sel[bcq_pkg::ADDR_CMPA_HIGH])
      begin
        st_d.cmpa_high = reg_wdata;
      end
      else if (reg_sel[bcq_pkg::ADDR_CMPA_LOW])
      begin
        st_d.cmpa_low = reg_wdata;
      end
      else if (reg_sel[bcq_pkg::ADDR_CMPB_EXT])
      begin
        st_d.cmpb_ext = reg_wdata;
      end
      else if (reg_sel[bcq_pkg::ADDR_CMPB_HIGH])
      begin
        st_d.cmpb_high = reg_wdata;
      end
      else if (reg_sel[bcq_pkg::ADDR_CMPB_LOW])
      begin
        st_d.cmpb_low = reg_wdata;
      end
      else if (reg_sel[bcq_pkg::ADDR_MODE_CTRL])
      begin
        st_d.mode = reg_wdata[2:0];
      end
    end

    // Read data stands only in the cycle after the strobe
    st_d.rdata = bcq_pkg::ZERO_BYTE;
    if (reg_rd)
    begin
      if (reg_sel[bcq_pkg::ADDR_QUAL_CTRL])
      begin
        st_d.rdata = st_q.qual_ctrl;
      end
      else if (reg_sel[bcq_pkg::ADDR_CMPA_EXT])
      begin
        st_d.rdata = st_q.cmpa_ext;
      end
      else if (reg_sel[bcq_pkg::ADDR_CMPA_HIGH])
      begin
        st_d.rdata = st_q.cmpa_high;
      end
      else if (reg_sel[bcq_pkg::ADDR_CMPA_LOW])
      begin
        st_d.rdata = st_q.cmpa_low;
      end
      else if (reg_sel[bcq_pkg::ADDR_CMPB_EXT])
      begin
        st_d.rdata = st_q.cmpb_ext;
      end
      else if (reg_sel[bcq_pkg::ADDR_CMPB_HIGH])
      begin
        st_d.rdata = st_q.cmpb_high;
      end
      else if (reg_sel[bcq_pkg::ADDR_CMPB_LOW])
      begin
        st_d.rdata = st_q.cmpb_low;
      end
      else if (reg_sel[bcq_pkg::ADDR_MODE_CTRL])
      begin
        st_d.rdata = {5'h00, st_q.mode};
      end
      else if (reg_sel[bcq_pkg::ADDR_STATUS])
      begin
        st_d.rdata = {6'h00, st_q.match_b, st_q.match_a};
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // All state in one register, frozen while the enable is low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q.qual_ctrl <= bcq_pkg::QUAL_CTRL_RST;
      st_q.cmpa_ext  <= bcq_pkg::BYTE_RST;
      st_q.cmpa_high <= bcq_pkg::BYTE_RST;
      st_q.cmpa_low  <= bcq_pkg::BYTE_RST;
      st_q.cmpb_ext  <= bcq_pkg::BYTE_RST;
      st_q.cmpb_high <= bcq_pkg::BYTE_RST;
      st_q.cmpb_low  <= bcq_pkg::BYTE_RST;
      st_q.mode      <= bcq_pkg::MODE_RST;
      st_q.rdata     <= bcq_pkg::BYTE_RST;
      st_q.match_a   <= 1'b0;
      st_q.match_b   <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Outputs straight from the state register
  assign reg_rdata = st_q.rdata;
  assign match_a   = st_q.match_a;
  assign match_b   = st_q.match_b;

endmodule : bcq_top

// File: verification/bcq_checker.sv
// Purpose: Port assertions for the breakpoint compare qualifier
// Assumes: Control and mode registers are shadowed from port writes
// Notes:   Bound to every bcq_top
`timescale 1ns/1ps
module bcq_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        page_access,
  input wire logic        cpu_read,
  input wire logic        cpu_valid,
  input wire logic        match_a,
  input wire logic        match_b
);
  logic [7:0] ctl_q;
  logic [2:0] mode_q;
  logic       trace;
  // Shadow of the control and mode registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_q  <= 8'h00;
      mode_q <= 3'h0;
    end
    else if (clk_en && reg_wr)
    begin
      if (reg_addr == bcq_pkg::ADDR_QUAL_CTRL) ctl_q <= reg_wdata;
      if (reg_addr == bcq_pkg::ADDR_MODE_CTRL) mode_q <= reg_wdata[2:0];
    end
  end
  assign trace = mode_q[0] && !mode_q[2];
  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_match_a_cause: assert property (
    $rose(match_a) |-> $past(cpu_valid))
    else $error("match_a rose without a bus cycle");
  chk_match_b_cause: assert property (
    $rose(match_b) |-> $past(cpu_valid))
    else $error("match_b rose without a bus cycle");
  chk_ctrl_read: assert property (
    reg_rd && reg_addr == bcq_pkg::ADDR_QUAL_CTRL
    |=> reg_rdata == $past(ctl_q))
    else $error("control register read back wrong");
  chk_dir_a_reject: assert property (
    cpu_valid && ctl_q[3] && cpu_read != ctl_q[2] |=> !match_a)
    else $error("match_a on wrong cycle direction");
  chk_dir_b_reject: assert property (
    cpu_valid && !mode_q[1] && ctl_q[1] && cpu_read != ctl_q[0]
    |=> !match_b)
    else $error("match_b on wrong cycle direction");
  chk_full_b_open: assert property (
    cpu_valid && mode_q[2:1] == 2'b11 && ctl_q[5:4] == 2'b11
    |=> match_b)
    else $error("match_b missing with data compare off");
  chk_page_only_a: assert property (
    cpu_valid && !page_access && !trace && ctl_q[7:6] == 2'b11
    |=> !match_a)
    else $error("match_a outside a program page");
  chk_page_only_b: assert property (
    cpu_valid && !page_access && !mode_q[1] && ctl_q[5:4] == 2'b11
    |=> !match_b)
    else $error("match_b outside a program page");
endmodule : bcq_checker

bind bcq_top bcq_checker u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .page_access(page_access),
  .cpu_read(cpu_read), .cpu_valid(cpu_valid), .match_a(match_a),
  .match_b(match_b));

// File: verification/bcq_core_bus.sv
// Purpose: Model of the core address, data and page bus
// Assumes: One bus cycle per clock while drive is high
// Notes:   Idle lines show the inverse of the last cycle
`timescale 1ns/1ps
module bcq_core_bus (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        drive,
  input  wire logic [39:0] req,
  output logic      [15:0] cpu_addr,
  output logic      [15:0] cpu_data,
  output logic      [5:0]  cpu_page,
  output logic             page_access,
  output logic             cpu_read,
  output logic             cpu_valid
);
  logic [39:0] last_q;
  // ********************
  // Bus lines
  // ********************
  always_comb
  begin
    cpu_valid = drive;
    {cpu_addr, cpu_data, cpu_page, page_access, cpu_read} =
      drive ? req : ~last_q;
  end
  // Remember the last cycle so idle lines never repeat it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) last_q <= 40'h0;
    else if (drive) last_q <= req;
  end
endmodule : bcq_core_bus

// File: verification/bcq_top_test.sv
// Purpose: Self-checking bench for the breakpoint compare qualifier
// Assumes: Expected matches come from a local reference of the compares
// Notes:   clk_en is held high
`timescale 1ns/1ps
module bcq_top_test;
  localparam logic [15:0] PROBE [0:4] = '{16'h0000, 16'h0001, 16'h0100,
                                          16'h0000, 16'hC000};
  logic        clk, rst_n, reg_wr, reg_rd, drive, match_a, match_b, pa, cr, cv;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [39:0] req;
  logic [15:0] ca, cd;
  logic [5:0]  cp;
  logic [7:0]  sh [0:7];
  int          fail_count, checks;
  bcq_core_bus u_bus (.clk(clk), .rst_n(rst_n), .drive(drive), .req(req),
    .cpu_addr(ca), .cpu_data(cd), .cpu_page(cp), .page_access(pa),
    .cpu_read(cr), .cpu_valid(cv));
  bcq_top u_dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_addr(ca), .cpu_data(cd),
    .program_page_select(cp), .page_access(pa), .cpu_read(cr),
    .cpu_valid(cv), .match_a(match_a), .match_b(match_b));
  // ********************
  // Shared tasks
  // ********************
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    if (a < 4'h8) sh[a[2:0]] = d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask : rdc
  function automatic logic aok(logic [1:0] m, logic [7:0] x, h, l,
                               logic [15:0] a, logic [5:0] p, logic g);
    logic ok;
    if (m == 2'b11) return g && x[5:0] == p;
    ok = g ? (x[5:0] == p && h[5:0] == a[13:8]) : h == a[15:8];
    return ok && (m[0] || l == a[7:0]);
  endfunction : aok
  task automatic bus(logic [15:0] a, d, logic [5:0] p, logic g, r);
    logic ea, eb, tr;
    tr = sh[7][0] && !sh[7][2];
    ea = aok(tr ? 2'b00 : sh[0][7:6], sh[1], sh[2], sh[3], a, p, g)
         && (!sh[0][3] || r == sh[0][2]);
    if (sh[7][1])
      eb = (sh[0][5] || sh[5] == d[15:8]) && (sh[0][4] || sh[6] == d[7:0]);
    else
      eb = aok(sh[0][5:4], sh[4], sh[5], sh[6], a, p, g)
           && (!sh[0][1] || r == sh[0][0]);
    @(posedge clk);
    drive <= 1'b1;
    req   <= {a, d, p, g, r};
    @(posedge clk);
    drive <= 1'b0;
    #1 chk("match_a", match_a, ea);
    chk("match_b", match_b, eb);
  endtask : bus
  // Reset value, read back, unmapped index
  task automatic t_regs;
    rdc(bcq_pkg::ADDR_QUAL_CTRL, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      wr(i[3:0], 8'hA5 ^ i[7:0]);
      rdc(i[3:0], 8'hA5 ^ i[7:0]);
    end
    wr(4'hF, 8'hFF);
    rdc(4'hF, 8'h00);
  endtask : t_regs
  // Every address mask, paged and unpaged, on both comparators
  task automatic t_addr;
    wr(bcq_pkg::ADDR_MODE_CTRL, 8'h00);
    for (int i = 1; i < 7; i++)
      wr(i[3:0], (i % 3 == 1) ? 8'h15 : (i % 3 == 2) ? 8'h5A : 8'h3C);
    for (int m = 0; m < 4; m++)
    begin
      wr(bcq_pkg::ADDR_QUAL_CTRL, {m[1:0], m[1:0], 4'h0});
      for (int v = 0; v < 10; v++)
        bus(16'h5A3C ^ PROBE[v % 5], 16'h0000,
            6'h15 ^ 6'(v % 5 == 3), v > 4, v[0]);
    end
  endtask : t_addr
  // Data byte masks in full mode with contrary direction bits
  task automatic t_full;
    wr(bcq_pkg::ADDR_MODE_CTRL, 8'h06);
    wr(bcq_pkg::ADDR_CMPB_EXT, 8'h2A);
    wr(bcq_pkg::ADDR_CMPB_HIGH, 8'h12);
    wr(bcq_pkg::ADDR_CMPB_LOW, 8'h34);
    for (int m = 0; m < 4; m++)
    begin
      wr(bcq_pkg::ADDR_QUAL_CTRL, {2'b00, m[1:0], 4'h2});
      for (int v = 0; v < 4; v++)
        bus(16'h5A3C, 16'h1234 ^ {7'h0, v[1], 7'h0, v[0]},
            6'h15, 1'b1, 1'b1);
    end
  endtask : t_full
  // All direction settings against reads and writes
  // Direction is only used on plain, never tagged, breakpoints
  task automatic t_dir;
    wr(bcq_pkg::ADDR_MODE_CTRL, 8'h00);
    wr(bcq_pkg::ADDR_CMPB_EXT, 8'h15);
    wr(bcq_pkg::ADDR_CMPB_HIGH, 8'h5A);
    wr(bcq_pkg::ADDR_CMPB_LOW, 8'h3C);
    for (int c = 0; c < 32; c++)
    begin
      if (!c[0]) wr(bcq_pkg::ADDR_QUAL_CTRL, {4'h0, c[4:1]});
      bus(16'h5A3C, 16'h0000, 6'h15, 1'b1, c[0]);
    end
  endtask : t_dir
  // Trace mode drops mask A, breakpoint mode keeps it
  // Exact breakpoints are set in trace mode, not breakpoint mode
  task automatic t_trace;
    wr(bcq_pkg::ADDR_QUAL_CTRL, 8'hC0);
    wr(bcq_pkg::ADDR_MODE_CTRL, 8'h01);
    bus(16'h5A3D, 16'h0000, 6'h15, 1'b1, 1'b0);
    wr(bcq_pkg::ADDR_MODE_CTRL, 8'h05);
    bus(16'h5A3D, 16'h0000, 6'h15, 1'b1, 1'b0);
  endtask : t_trace
  task automatic results;
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  // Clock, watchdog and main sequence
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #400000;
    fail_count++;
    results();
  end
  initial
  begin
    rst_n  = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    drive  = 1'b0;
    req    = 40'h0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_addr();
    t_full();
    t_dir();
    t_trace();
    results();
  end
endmodule : bcq_top_test
